/* verilog/aeo_top.sv */
// angle encoder outputs: quadrature A/B with index Z, commutation
// U/V/W or differential complements, and a frame-coded pwm output.
// assumes the measured angle, velocity and radius arrive synchronous
// to clk_in, and that software writes the configuration registers.
`timescale 1ns/100ps
`include "aeo_regs.svh"
module aeo_top #(
  parameter int STARTUP_CYC = `AEO_STARTUP_CYC
)
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire aeo_pkg::aeo_angle_t angle_in,
  input wire aeo_pkg::aeo_word_t velocity_in,
  input wire aeo_pkg::aeo_word_t radius_in,
  input wire logic [3:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out,
  output logic quad_a_out,
  output logic quad_b_out,
  output logic index_z_out,
  output logic pin_u_out,
  output logic pin_v_out,
  output logic pin_w_out,
  output logic pwm_out
);
  import aeo_pkg::*;

  // configuration registers
  logic [11:0] zero_offset_ff;
  logic [11:0] quad_resolution_ff;
  logic [7:0] cfg_ff;
  logic [3:0] commutation_pole_pairs_ff;

  // startup blocking
  aeo_start_e start_ff;
  logic [31:0] start_cnt_ff;

  // position datapath
  logic [17:0] corr_angle;
  logic [14:0] steps;
  logic [32:0] pos_full;
  logic [13:0] pos;
  logic [2:0] zw_code;
  logic diff_mode;
  logic pwm_slow;
  aeo_src_e src_sel;
  logic quad_a;
  logic quad_b;
  logic index_z;

  // registered pin state
  logic a_ff;
  logic b_ff;
  logic z_ff;
  logic u_ff;
  logic v_ff;
  logic w_ff;
  logic pwm_ff;
  logic [7:0] rdata_ff;

  aeo_link_if lnk ();

  // index width in steps; zero marks the half-turn code
  function automatic logic [4:0] zw_steps(input logic [2:0] code);
    case (code)
      3'h0: zw_steps = 5'h01;
      3'h1: zw_steps = 5'h02;
      3'h2: zw_steps = 5'h04;
      3'h3: zw_steps = 5'h08;
      3'h4: zw_steps = 5'h0c;
      3'h5: zw_steps = 5'h10;
      3'h6: zw_steps = 5'h00;
      default: zw_steps = 5'h01;
    endcase
  endfunction

  // gray sequence 00,10,11,01 as the step count rises
  function automatic logic [1:0] quad_ab(input logic [1:0] ph);
    case (ph)
      2'h0: quad_ab = 2'b00;
      2'h1: quad_ab = 2'b10;
      2'h2: quad_ab = 2'b11;
      2'h3: quad_ab = 2'b01;
      default: quad_ab = 2'b00;
    endcase
  endfunction

  // ---------------- register writes ----------------

  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
      zero_offset_ff <= `AEO_RST_ZERO;
    else if (reg_wr_in && reg_addr_in == `AEO_REG_ZERO_HI)
      zero_offset_ff[11:8] <= reg_wdata_in[3:0];
    else if (reg_wr_in && reg_addr_in == `AEO_REG_ZERO_LO)
      zero_offset_ff[7:0] <= reg_wdata_in;
  end

  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
      quad_resolution_ff <= `AEO_RST_RES;
    else if (reg_wr_in && reg_addr_in == `AEO_REG_RES_HI)
      quad_resolution_ff[11:8] <= reg_wdata_in[3:0];
    else if (reg_wr_in && reg_addr_in == `AEO_REG_RES_LO)
      quad_resolution_ff[7:0] <= reg_wdata_in;
  end

  // reset value selects angle on pwm, as the pin's default function
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
      cfg_ff <= `AEO_RST_CFG;
    else if (reg_wr_in && reg_addr_in == `AEO_REG_CFG)
      cfg_ff <= {1'b0, reg_wdata_in[6:0]};
  end

  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
      commutation_pole_pairs_ff <= `AEO_RST_POLE;
    else if (reg_wr_in && reg_addr_in == `AEO_REG_POLE)
      commutation_pole_pairs_ff <= reg_wdata_in[3:0];
  end

  assign zw_code = cfg_ff[`AEO_CFG_ZW_LSB +: 3];
  assign diff_mode = cfg_ff[`AEO_CFG_DIFF_BIT];
  assign pwm_slow = cfg_ff[`AEO_CFG_PWMF_BIT];
  assign src_sel = aeo_src_e'(cfg_ff[`AEO_CFG_SEL_LSB +: 2]);

  // ---------------- register reads ----------------

  // data stands one cycle only; idle and unmapped reads give zero
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in || !reg_rd_in)
      rdata_ff <= 8'h00;
    else
    begin
      case (reg_addr_in)
        `AEO_REG_ZERO_HI: rdata_ff <= {4'h0, zero_offset_ff[11:8]};
        `AEO_REG_ZERO_LO: rdata_ff <= zero_offset_ff[7:0];
        `AEO_REG_RES_HI: rdata_ff <= {4'h0, quad_resolution_ff[11:8]};
        `AEO_REG_RES_LO: rdata_ff <= quad_resolution_ff[7:0];
        `AEO_REG_CFG: rdata_ff <= cfg_ff;
        `AEO_REG_POLE: rdata_ff <= {4'h0, commutation_pole_pairs_ff};
        `AEO_REG_STATUS:
          rdata_ff <= {1'b0, w_ff, v_ff, u_ff, pwm_ff, z_ff, b_ff,
                       start_ff == ST_RUN};
        `AEO_REG_ANGLE: rdata_ff <= corr_angle[17:10];
        default: rdata_ff <= 8'h00;
      endcase
    end
  end

  assign reg_rdata_out = rdata_ff;

  // ---------------- startup blocking ----------------

  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      start_ff <= ST_BLOCK;
      start_cnt_ff <= 32'h0000_0000;
    end
    else
    begin
      case (start_ff)
        ST_BLOCK:
          if (start_cnt_ff == 32'(STARTUP_CYC - 1))
            start_ff <= ST_RUN;
          else
            start_cnt_ff <= start_cnt_ff + 32'h0000_0001;
        ST_RUN:
          start_ff <= ST_RUN;
        default:
          start_ff <= ST_BLOCK;
      endcase
    end
  end

  // ---------------- quadrature and index ----------------

  // zero offset is 12 bits of a turn; it aligns to the angle's top bits
  assign corr_angle = angle_in - {zero_offset_ff, 6'h00};

  // four steps per pulse; 4096 pulses give 16384 steps
  assign steps = {1'b0, quad_resolution_ff, 2'b00} + 15'h0004;

  // scaling keeps step edges monotonic with the angle
  assign pos_full = corr_angle * steps;
  assign pos = pos_full[31:18];

  // rising steps give A before B; falling steps reverse it
  assign {quad_a, quad_b} = quad_ab(pos[1:0]);

  // pulse starts at step zero, so it appears once per turn
  always_comb
  begin
    if (zw_code == 3'h6)
      index_z = !corr_angle[17];
    else
      index_z = pos < {9'h000, zw_steps(zw_code)};
  end

  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in || start_ff != ST_RUN)
    begin
      a_ff <= 1'b0;
      b_ff <= 1'b0;
      z_ff <= 1'b0;
    end
    else
    begin
      a_ff <= quad_a;
      b_ff <= quad_b;
      z_ff <= index_z;
    end
  end

  assign quad_a_out = a_ff;
  assign quad_b_out = b_ff;
  assign index_z_out = z_ff;

  // ---------------- commutation / differential pins ----------------

  assign lnk.angle = corr_angle;
  assign lnk.pole_code = commutation_pole_pairs_ff;

  aeo_uvw u_uvw
  (
    .lnk(lnk.mp_uvw)
  );

  // complements come from the blocked a/b/z, so a pair never disagrees
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      u_ff <= 1'b0;
      v_ff <= 1'b0;
      w_ff <= 1'b0;
    end
    else if (diff_mode)
    begin
      u_ff <= !((start_ff == ST_RUN) && quad_a);
      v_ff <= !((start_ff == ST_RUN) && quad_b);
      w_ff <= !((start_ff == ST_RUN) && index_z);
    end
    else
    begin
      u_ff <= lnk.u;
      v_ff <= lnk.v;
      w_ff <= lnk.w;
    end
  end

  assign pin_u_out = u_ff;
  assign pin_v_out = v_ff;
  assign pin_w_out = w_ff;

  // ---------------- pwm ----------------

  // reserved code falls back to angle rather than a stuck output
  always_comb
  begin
    case (src_sel)
      SRC_ANGLE: lnk.pwm_value = corr_angle[17:6];
      SRC_VEL: lnk.pwm_value = velocity_in;
      SRC_RADIUS: lnk.pwm_value = radius_in;
      default: lnk.pwm_value = corr_angle[17:6];
    endcase
  end

  assign lnk.pwm_slow = pwm_slow;

  aeo_pwm #(
    .DIV_W(6)
  ) u_pwm
  (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .lnk(lnk.mp_pwm)
  );

  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
      pwm_ff <= 1'b0;
    else
      pwm_ff <= lnk.pwm_level;
  end

  assign pwm_out = pwm_ff;
endmodule

/* verilog/aeo_regs.svh */
// register offsets, field positions, reset values and timing counts
// of the angle encoder output block; definitions only.
// Overview of operation
// - ccw rotation: B leads A by quarter cycle
// - cw rotation: A leads B, one step
// - hold A/B/Z blocked 16 ms after reset
// - 3-bit index width select, eight codes
// - one index pulse per turn at zero
// - 12-bit zero offset, high and low parts
// - resolution 1 to 4096 pulses, 12-bit field
// - top setting gives 16384 quadrature steps
// - differential mode drives complements on U/V/W
// - U, V, W shifted 120 electrical degrees
// - commutation cycles per turn equal code plus one
// - PWM duty tracks value, default pin function
// - frame of 4119 PWM clocks, 12-bit value
// - PWM clock 250 ns by default; the divider gives 13 clocks, 260 ns
// - 1-bit select picks PWM clock period
// - 2-bit select: angle, velocity or radius
`ifndef AEO_REGS_SVH
`define AEO_REGS_SVH

`define AEO_REG_ZERO_HI 4'h0
`define AEO_REG_ZERO_LO 4'h1
`define AEO_REG_RES_HI 4'h2
`define AEO_REG_RES_LO 4'h3
`define AEO_REG_CFG 4'h4
`define AEO_REG_POLE 4'h5
`define AEO_REG_STATUS 4'h6
`define AEO_REG_ANGLE 4'h7

`define AEO_CFG_ZW_LSB 0
`define AEO_CFG_DIFF_BIT 3
`define AEO_CFG_PWMF_BIT 4
`define AEO_CFG_SEL_LSB 5

`define AEO_RST_ZERO 12'h000
`define AEO_RST_RES 12'hfff
`define AEO_RST_CFG 8'h00
`define AEO_RST_POLE 4'h0

`define AEO_CLK_NS 20
`define AEO_STARTUP_MS 16
`define AEO_STARTUP_CYC (`AEO_STARTUP_MS * 1000000 / `AEO_CLK_NS)
`define AEO_PWM_FAST_NS 250
`define AEO_PWM_SLOW_NS 500
`define AEO_PWM_FAST_CYC ((`AEO_PWM_FAST_NS + `AEO_CLK_NS - 1) / `AEO_CLK_NS)
`define AEO_PWM_SLOW_CYC ((`AEO_PWM_SLOW_NS + `AEO_CLK_NS - 1) / `AEO_CLK_NS)
`define AEO_PWM_FRAME 4119
`define AEO_PWM_HEAD 16

`endif

/* verilog/aeo_pkg.sv */
// types shared by the angle encoder output block.
// assumes nothing of its surroundings.
package aeo_pkg;
  typedef logic [17:0] aeo_angle_t;
  typedef logic [11:0] aeo_word_t;
  typedef enum logic [1:0] {ST_BLOCK = 2'h1, ST_RUN = 2'h2} aeo_start_e;
  typedef enum logic [1:0] {PWM_HIGH = 2'h1, PWM_LOW = 2'h2} aeo_pwm_e;
  typedef enum logic [1:0]
  {
    SRC_ANGLE = 2'h0,
    SRC_VEL = 2'h1,
    SRC_RADIUS = 2'h2,
    SRC_RSVD = 2'h3
  } aeo_src_e;
endpackage

/* verilog/aeo_link_if.sv */
// link between the top of the block and its commutation and pwm parts.
// all users sit on the one block clock.
`timescale 1ns/100ps
interface aeo_link_if;
  logic [17:0] angle;
  logic [3:0] pole_code;
  logic [11:0] pwm_value;
  logic pwm_slow;
  logic u;
  logic v;
  logic w;
  logic pwm_level;
  modport mp_top(output angle, pole_code, pwm_value, pwm_slow,
                 input u, v, w, pwm_level);
  modport mp_uvw(input angle, pole_code, output u, v, w);
  modport mp_pwm(input pwm_value, pwm_slow, output pwm_level);
endinterface

/* verilog/aeo_uvw.sv */
// three-phase commutation decode from the zero-corrected angle.
// combinational; the top registers the phases before the pins.
`timescale 1ns/100ps
module aeo_uvw
(
  aeo_link_if.mp_uvw lnk
);
  import aeo_pkg::*;
  logic [4:0] pairs;
  logic [22:0] elec_full;
  logic [17:0] elec;
  logic [20:0] sect_full;
  logic [2:0] sector;
  logic [2:0] ph;

  assign pairs = {1'b0, lnk.pole_code} + 5'h01;
  assign elec_full = lnk.angle * pairs;
  assign elec = elec_full[17:0];
  assign sect_full = elec * 3'h6;
  assign sector = sect_full[20:18];

  // each phase high for three of six sectors, two sectors apart
  for (genvar k = 0; k < 3; k++)
  begin : g_ph
    localparam logic [2:0] S0 = 3'(2 * k);
    localparam logic [2:0] S1 = 3'(2 * k + 1);
    localparam logic [2:0] S2 = 3'((2 * k + 2) % 6);
    assign ph[k] = (sector == S0) || (sector == S1) || (sector == S2);
  end

  assign lnk.u = ph[0];
  assign lnk.v = ph[1];
  assign lnk.w = ph[2];
endmodule

/* verilog/aeo_pwm.sv */
// pwm frame generator: head, value-long high part, low tail.
// value and period select come from the top over the link.
`timescale 1ns/100ps
`include "aeo_regs.svh"
module aeo_pwm #(
  parameter int DIV_W = 6
)
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  aeo_link_if.mp_pwm lnk
);
  import aeo_pkg::*;
  localparam logic [DIV_W-1:0] FAST = DIV_W'(`AEO_PWM_FAST_CYC - 1);
  localparam logic [DIV_W-1:0] SLOW = DIV_W'(`AEO_PWM_SLOW_CYC - 1);
  localparam logic [12:0] LAST = 13'(`AEO_PWM_FRAME - 1);
  localparam logic [12:0] HEAD = 13'(`AEO_PWM_HEAD);
  logic [DIV_W-1:0] div_ff;
  logic tick;
  logic [12:0] cnt_ff;
  logic [12:0] nxt_cnt;
  logic [11:0] val_ff;
  aeo_pwm_e state_ff;

  assign tick = div_ff == (lnk.pwm_slow ? SLOW : FAST);
  assign nxt_cnt = (cnt_ff == LAST) ? 13'h0000 : cnt_ff + 13'h0001;

  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in || tick)
      div_ff <= '0;
    else
      div_ff <= div_ff + DIV_W'(1);
  end

  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
      cnt_ff <= 13'h0000;
    else if (tick)
      cnt_ff <= nxt_cnt;
  end

  // value held for the whole frame so the duty never tears mid-frame
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
      val_ff <= 12'h000;
    else if (tick && cnt_ff == LAST)
      val_ff <= lnk.pwm_value;
  end

  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
      state_ff <= PWM_HIGH;
    else if (tick)
    begin
      case (state_ff)
        PWM_HIGH:
          if (nxt_cnt == HEAD + {1'b0, val_ff})
            state_ff <= PWM_LOW;
        PWM_LOW:
          if (nxt_cnt == 13'h0000)
            state_ff <= PWM_HIGH;
        default:
          state_ff <= PWM_HIGH;
      endcase
    end
  end

  assign lnk.pwm_level = state_ff == PWM_HIGH;
endmodule

/* dv/aeo_top_chk.sv */
// concurrent checks on the angle encoder output pins and register port.
// sees only the top ports; attached by the bind at the foot.
`timescale 1ns/100ps
`include "aeo_regs.svh"
module aeo_top_chk #(
  parameter int STARTUP_CYC = 50
)
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire aeo_pkg::aeo_angle_t angle_in,
  input wire logic [3:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic quad_a_out,
  input wire logic quad_b_out,
  input wire logic index_z_out,
  input wire logic pin_u_out,
  input wire logic pin_v_out,
  input wire logic pin_w_out,
  input wire logic pwm_out
);
  import aeo_pkg::*;
  localparam int FAST = 4119 * 13;
  localparam int SLOW = 4119 * 25;
  int cnt_ff;
  int fr_ff;
  int hi_ff;
  logic diff_ff;
  logic slow_ff;
  logic chg_ff;
  logic wr_cfg;
  assign wr_cfg = reg_wr_in && reg_addr_in == `AEO_REG_CFG;
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_n_in);
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
      cnt_ff <= 0;
    else if (cnt_ff < STARTUP_CYC + 8)
      cnt_ff <= cnt_ff + 1;
  end
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      diff_ff <= 1'b0;
      slow_ff <= 1'b0;
    end
    else if (wr_cfg)
    begin
      diff_ff <= reg_wdata_in[`AEO_CFG_DIFF_BIT];
      slow_ff <= reg_wdata_in[`AEO_CFG_PWMF_BIT];
    end
  end
  // a period change mid-frame gives a mixed frame, so skip that one
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      fr_ff <= 0;
      hi_ff <= 0;
      chg_ff <= 1'b0;
    end
    else
    begin
      fr_ff <= $rose(pwm_out) ? 1 : (fr_ff == 0 ? 0 : fr_ff + 1);
      hi_ff <= pwm_out ? hi_ff + 1 : 0;
      if ($rose(pwm_out))
        chg_ff <= 1'b0;
      else if (wr_cfg && reg_wdata_in[`AEO_CFG_PWMF_BIT] != slow_ff)
        chg_ff <= 1'b1;
    end
  end
  sequence settled_s;
    cnt_ff == STARTUP_CYC + 8;
  endsequence
  sequence quiet_s;
    (!reg_wr_in && $stable(angle_in)) [*3];
  endsequence
  abz_blocked_a: assert property (cnt_ff < STARTUP_CYC |->
    !quad_a_out && !quad_b_out && !index_z_out)
    else $error("abz driven during startup");
  rdata_idle_a: assert property (!$past(reg_rd_in) |->
    reg_rdata_out == 8'h00) else $error("read data without read");
  rsvd_bits_a: assert property ($past(reg_rd_in) &&
    $past(reg_addr_in) inside {4'h0, 4'h2, 4'h5} |->
    reg_rdata_out[7:4] == 4'h0) else $error("reserved bits set");
  diff_pins_a: assert property (diff_ff && $past(diff_ff) &&
    cnt_ff > 1 |-> {pin_u_out, pin_v_out, pin_w_out} ==
    ~{quad_a_out, quad_b_out, index_z_out})
    else $error("differential pins not complements");
  uvw_phase_a: assert property (!diff_ff && !$past(diff_ff) &&
    cnt_ff > 1 |-> {pin_u_out, pin_v_out, pin_w_out} != 3'b000 &&
    {pin_u_out, pin_v_out, pin_w_out} != 3'b111)
    else $error("illegal commutation state");
  pins_hold_a: assert property (settled_s ##0 quiet_s |=>
    $stable({quad_a_out, quad_b_out, index_z_out, pin_u_out}))
    else $error("pins moved with angle still");
  pwm_head_a: assert property ($fell(pwm_out) |->
    hi_ff >= 16 * 13 - 1) else $error("pwm head too short");
  pwm_frame_a: assert property ($rose(pwm_out) && fr_ff != 0 &&
    !chg_ff |-> fr_ff == (slow_ff ? SLOW : FAST))
    else $error("pwm frame length wrong");
endmodule

bind aeo_top aeo_top_chk #(.STARTUP_CYC(STARTUP_CYC)) u_chk (
  .clk_in(clk_in), .rst_n_in(rst_n_in), .angle_in(angle_in),
  .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
  .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
  .reg_rdata_out(reg_rdata_out), .quad_a_out(quad_a_out),
  .quad_b_out(quad_b_out), .index_z_out(index_z_out),
  .pin_u_out(pin_u_out), .pin_v_out(pin_v_out), .pin_w_out(pin_w_out),
  .pwm_out(pwm_out));

/* dv/aeo_ctrl_model.sv */
// motor controller model: decodes quadrature into a position count
// and counts index rises; samples the pins on the block clock.
`timescale 1ns/100ps
module aeo_ctrl_model
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic a_in,
  input wire logic b_in,
  input wire logic z_in,
  output int pos_out,
  output int idx_out
);
  logic [1:0] ph_ff;
  logic [1:0] ph;
  logic z_ff;
  assign ph = {b_in, a_in ^ b_in};
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      ph_ff <= 2'h0;
      z_ff <= 1'b0;
      pos_out <= 0;
      idx_out <= 0;
    end
    else
    begin
      ph_ff <= ph;
      z_ff <= z_in;
      // a two-phase jump has no direction, so it is not counted
      if (ph == ph_ff + 2'h1)
        pos_out <= pos_out + 1;
      else if (ph == ph_ff - 2'h1)
        pos_out <= pos_out - 1;
      if (z_in && !z_ff)
        idx_out <= idx_out + 1;
    end
  end
endmodule

/* dv/testbench.sv */
// self-checking bench for the angle encoder output block.
// drives registers and angle; a controller model reads the pins.
`timescale 1ns/100ps
`include "aeo_regs.svh"
module testbench;
  import aeo_pkg::*;
  localparam int STUP = 50;
  localparam logic [1:0] AB [4] = '{2'b00, 2'b10, 2'b11, 2'b01};
  localparam int ZW [8] = '{1, 2, 4, 8, 12, 16, 8192, 1};
  localparam aeo_angle_t ZOFF = 18'h048c0;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  aeo_angle_t ang = 18'h00000;
  aeo_word_t vel = 12'h010;
  aeo_word_t rad = 12'h020;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdat = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] rdat;
  logic qa, qb, qz, pu, pv, pw, pwm;
  int n_fail = 0;
  int compares = 0;
  int pcnt;
  int zcnt;
  int hi_run = 0;
  int hi_last = 0;
  always #10 clk_in = ~clk_in;
  // length of the last completed high run of pwm, in cycles
  always @(negedge clk_in)
  begin
    if (pwm === 1'b1)
      hi_run <= hi_run + 1;
    else
    begin
      if (hi_run != 0)
        hi_last <= hi_run;
      hi_run <= 0;
    end
  end
  aeo_top #(.STARTUP_CYC(STUP)) u_dut (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .angle_in(ang), .velocity_in(vel), .radius_in(rad), .reg_addr_in(addr),
    .reg_wdata_in(wdat), .reg_wr_in(wr), .reg_rd_in(rd),
    .reg_rdata_out(rdat), .quad_a_out(qa), .quad_b_out(qb),
    .index_z_out(qz), .pin_u_out(pu), .pin_v_out(pv), .pin_w_out(pw),
    .pwm_out(pwm));
  aeo_ctrl_model u_ctrl (.clk_in(clk_in), .rst_n_in(rst_n_in), .a_in(qa),
    .b_in(qb), .z_in(qz), .pos_out(pcnt), .idx_out(zcnt));
  task automatic final_report();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_in);
    addr <= a;
    wdat <= d;
    wr <= 1'b1;
    @(posedge clk_in);
    wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk_in);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_in);
    rd <= 1'b0;
    @(negedge clk_in);
    chk(32'(rdat), 32'(e));
  endtask
  task automatic set_ang(input aeo_angle_t v);
    @(posedge clk_in);
    ang <= v;
    repeat (2) @(posedge clk_in);
    @(negedge clk_in);
  endtask
  task automatic wait_pwm(input logic lvl);
    int i;
    for (i = 0; i < 60000 && pwm !== lvl; i++)
      @(negedge clk_in);
    if (pwm !== lvl)
    begin
      n_fail++;
      $display("[FAIL] %0t pwm level wait timed out", $time);
      final_report();
    end
  endtask
  task automatic t_startup();
    int i;
    ang <= 18'h00030;
    repeat (2) @(negedge clk_in);
    chk(32'(pwm), 32'h1);
    for (i = 0; i < STUP - 4; i++)
    begin
      @(negedge clk_in);
      chk(32'({qa, qb, qz}), 32'h0);
    end
    repeat (8) @(negedge clk_in);
    chk(32'({qa, qb, qz}), 32'h2);
  endtask
  task automatic t_reset();
    rd_chk(`AEO_REG_ZERO_HI, 8'h00);
    rd_chk(`AEO_REG_ZERO_LO, 8'h00);
    rd_chk(`AEO_REG_RES_HI, 8'h0f);
    rd_chk(`AEO_REG_RES_LO, 8'hff);
    rd_chk(`AEO_REG_CFG, 8'h00);
    rd_chk(`AEO_REG_POLE, 8'h00);
    rd_chk(4'h9, 8'h00);
  endtask
  task automatic t_quad();
    int k;
    int p0;
    set_ang(18'h00000);
    p0 = pcnt;
    for (k = 1; k <= 8; k++)
    begin
      set_ang(18'(k * 16));
      chk(32'({qa, qb}), 32'(AB[k % 4]));
    end
    chk(32'(pcnt - p0), 32'd8);
    for (k = 7; k >= 0; k--)
    begin
      set_ang(18'(k * 16));
      chk(32'({qa, qb}), 32'(AB[k % 4]));
    end
    chk(32'(pcnt - p0), 32'd0);
  endtask
  task automatic t_index();
    int i;
    for (i = 0; i < 8; i++)
    begin
      wr_reg(`AEO_REG_CFG, 8'(i));
      set_ang(18'((ZW[i] - 1) * 16));
      chk(32'(qz), 32'h1);
      set_ang(18'(ZW[i] * 16));
      chk(32'(qz), 32'h0);
    end
    wr_reg(`AEO_REG_ZERO_HI, 8'hf1);
    wr_reg(`AEO_REG_ZERO_LO, 8'h23);
    rd_chk(`AEO_REG_ZERO_HI, 8'h01);
    set_ang(ZOFF);
    chk(32'(qz), 32'h1);
    set_ang(ZOFF - 18'h00010);
    chk(32'(qz), 32'h0);
  endtask
  task automatic t_turn();
    int k;
    int p0;
    int z0;
    wr_reg(`AEO_REG_RES_HI, 8'h00);
    wr_reg(`AEO_REG_RES_LO, 8'h00);
    set_ang(ZOFF + 18'h20000);
    p0 = pcnt;
    z0 = zcnt;
    for (k = 1; k <= 64; k++)
      set_ang(ZOFF + 18'h20000 + 18'(k * 4096));
    chk(32'(pcnt - p0), 32'd4);
    chk(32'(zcnt - z0), 32'd1);
  endtask
  task automatic t_uvw();
    int p;
    int j;
    int s;
    logic [17:0] e;
    for (p = 0; p < 16; p += 5)
    begin
      wr_reg(`AEO_REG_POLE, 8'(p));
      for (j = 0; j < 44; j++)
      begin
        e = 18'(j * 6000 * (p + 1));
        s = (int'(e) * 6) >> 18;
        set_ang(ZOFF + 18'(j * 6000));
        chk(32'({pu, pv, pw}),
          32'({s <= 2, s >= 2 && s <= 4, s >= 4 || s == 0}));
      end
    end
  endtask
  task automatic t_diff();
    wr_reg(`AEO_REG_CFG, 8'h08);
    set_ang(ZOFF);
    chk(32'({pu, pv, pw}), 32'h6);
    set_ang(ZOFF + 18'h10000);
    chk(32'({pu, pv, pw}), 32'h3);
    rd_chk(`AEO_REG_ANGLE, 8'h40);
  endtask
  // first frame head carries value 0 at the fast clock; the second
  // frame carries velocity, switched to the slow clock before its
  // first tick so that every tick of that head is a slow one
  task automatic t_pwm();
    chk(32'(hi_last), 32'(`AEO_PWM_HEAD * `AEO_PWM_FAST_CYC));
    wr_reg(`AEO_REG_CFG, 8'h20);
    wait_pwm(1'b0);
    wait_pwm(1'b1);
    wr_reg(`AEO_REG_CFG, 8'h30);
    wait_pwm(1'b0);
    @(negedge clk_in);
    chk(32'(hi_last), 32'((`AEO_PWM_HEAD + 16) * `AEO_PWM_SLOW_CYC));
  endtask
  initial
  begin
    repeat (16) @(posedge clk_in);
    rst_n_in <= 1'b1;
    t_startup();
    t_reset();
    t_quad();
    t_index();
    t_turn();
    t_uvw();
    t_diff();
    t_pwm();
    final_report();
  end
endmodule
